// file: rtl/fsc_pkg.sv
/*
 * Shared constants and types for the loop reference, gain, secondary path
 * and hold-oscillate control block.
 * Assumes a 16-bit register port addressed at the printed register offsets.
 */
package fsc_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [15:0] OFS_L1_CTRL1    = 16'h0171;
	localparam logic [15:0] OFS_L2_CTRL1    = 16'h0191;
	localparam logic [15:0] OFS_L2_REFSEL   = 16'h0196;
	localparam logic [15:0] OFS_L2_GAIN     = 16'h0199;
	localparam logic [15:0] OFS_SYNC_ENA    = 16'h01A1;
	localparam logic [15:0] OFS_SYNC_INT    = 16'h01A2;
	localparam logic [15:0] OFS_SYNC_NUM    = 16'h01A3;
	localparam logic [15:0] OFS_SYNC_DEN    = 16'h01A4;
	localparam logic [15:0] OFS_SYNC_RATIO  = 16'h01A5;
	localparam logic [15:0] OFS_SYNC_REFSEL = 16'h01A6;
	localparam logic [15:0] OFS_SYNC_GAINBW = 16'h01A7;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int ENA_BIT    = 0;
	localparam int HOLD_BIT   = 1;
	localparam int GAIN_LSB   = 2;
	localparam int RATIO_LSB  = 8;
	localparam int DIV_LSB    = 6;
	localparam int SRC_LSB    = 0;
	localparam int BW_BIT     = 0;
	localparam int INT_W      = 10;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic       RST_L1_HOLD = 1'b1;
	localparam logic       RST_L2_HOLD = 1'b0;
	localparam logic       RST_ENA     = 1'b0;
	localparam logic       RST_BW      = 1'b1;
	localparam logic [3:0] RST_GAIN    = 4'h0;
	localparam logic [3:0] RST_SRC     = 4'h0;
	localparam logic [1:0] RST_DIV     = 2'h0;
	localparam logic [2:0] RST_RATIO   = 3'h0;
	localparam logic [15:0] RST_WORD   = 16'h0000;

	// ---------------------------------------------------------------
	// Reference source codes
	// ---------------------------------------------------------------
	localparam logic [3:0] SRC_MCLK_ONE = 4'h0;
	localparam logic [3:0] SRC_MCLK_TWO = 4'h1;
	localparam logic [3:0] SRC_SERIAL   = 4'h3;
	localparam logic [3:0] SRC_LOOP1    = 4'h4;
	localparam logic [3:0] SRC_LOOP2    = 4'h5;
	localparam logic [3:0] SRC_BCLK1    = 4'h8;
	localparam logic [3:0] SRC_BCLK2    = 4'h9;
	localparam logic [3:0] SRC_BCLK3    = 4'hA;
	localparam logic [3:0] SRC_FRM1     = 4'hC;
	localparam logic [3:0] SRC_FRM2     = 4'hD;
	localparam logic [3:0] SRC_FRM3     = 4'hE;

	// Presence of each candidate reference clock
	typedef struct packed {
		logic master_clock_in_one;
		logic master_clock_in_two;
		logic serial_bus_clock;
		logic loop1_out;
		logic loop2_out;
		logic audio_port1_bit_clock;
		logic audio_port2_bit_clock;
		logic audio_port3_bit_clock;
		logic audio_port1_rx_frame_clock;
		logic audio_port2_rx_frame_clock;
		logic audio_port3_rx_frame_clock;
	} fsc_ref_alive_t;

	// Secondary path configuration presented to the oscillator core
	typedef struct packed {
		logic        path_enable;
		logic [9:0]  integer_mult;
		logic [15:0] numerator;
		logic [15:0] denominator;
		logic [4:0]  vco_ratio;
		logic [3:0]  ref_divider;
		logic [3:0]  ref_source;
		logic [8:0]  gain;
		logic        narrow_bw;
	} fsc_sync_cfg_t;

endpackage : fsc_pkg

// file: rtl/fsc_control.sv
/*
 * Register file and loop control for two frequency-locked loops: reference
 * selection, gain decode, secondary path fields, hold-oscillate behaviour
 * and the held integrator driving each oscillator.
 * Assumes synchronous register strobes and per-loop error inputs from the
 * phase detectors; clock presence flags are synchronous to clk.
 */
`timescale 1ns/1ps
module fsc_control #(
	parameter int          INTEG_W    = 16,
	parameter logic [15:0] INTEG_INIT = 16'h8000
) (
	input  wire logic                    clk,
	input  wire logic                    nrst,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [15:0]             reg_addr,
	input  wire logic [15:0]             reg_wdata,
	output logic [15:0]                  reg_rdata,
	output logic                         reg_rvalid,
	input  wire fsc_pkg::fsc_ref_alive_t ref_alive,
	input  wire logic                    loop1_ref_alive,
	input  wire logic signed [15:0]      loop1_error,
	input  wire logic signed [15:0]      loop2_error,
	input  wire logic signed [15:0]      loop2_sync_error,
	input  wire logic                    main_system_clock_loop_sel,
	input  wire logic                    asynchronous_system_clock_loop_sel,
	output logic [INTEG_W-1:0]           loop1_osc_ctrl,
	output logic [INTEG_W-1:0]           loop2_osc_ctrl,
	output logic [1:0]                   loop_tracking,
	output logic [INTEG_W-1:0]           main_system_clock_ctrl,
	output logic [INTEG_W-1:0]           asynchronous_system_clock_ctrl,
	output fsc_pkg::fsc_sync_cfg_t       sync_cfg
);
	import fsc_pkg::*;

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------

	// Shift amount for a four-bit gain code
	function automatic logic [3:0] gain_shift(input logic [3:0] code);
		gain_shift = code[3] ? 4'h8 : {1'b0, code[2:0]};
	endfunction : gain_shift

	// Presence of the reference named by a source code; reserved gives none
	function automatic logic pick_ref(input fsc_ref_alive_t a, input logic [3:0] code,
		input logic is_sync);
		unique case (code)
			SRC_MCLK_ONE: pick_ref = a.master_clock_in_one;
			SRC_MCLK_TWO: pick_ref = a.master_clock_in_two;
			SRC_SERIAL:   pick_ref = a.serial_bus_clock;
			SRC_LOOP1:    pick_ref = a.loop1_out;
			SRC_LOOP2:    pick_ref = a.loop2_out;
			SRC_BCLK1:    pick_ref = a.audio_port1_bit_clock;
			SRC_BCLK2:    pick_ref = a.audio_port2_bit_clock;
			SRC_BCLK3:    pick_ref = a.audio_port3_bit_clock;
			SRC_FRM1:     pick_ref = a.audio_port1_rx_frame_clock;
			SRC_FRM2:     pick_ref = is_sync ? 1'b0 : a.audio_port2_rx_frame_clock;
			SRC_FRM3:     pick_ref = a.audio_port3_rx_frame_clock;
			default:      pick_ref = 1'b0;
		endcase
	endfunction : pick_ref

	// Integrator step: error scaled by a power of two, truncated to width
	function automatic logic [INTEG_W-1:0] scaled(input logic signed [15:0] e,
		input logic [3:0] sh);
		logic signed [31:0] wide;
		wide = 32'(e) <<< sh;
		scaled = wide[INTEG_W-1:0];
	endfunction : scaled

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [1:0]  loop1_ctrl_r;
	logic [1:0]  loop2_ctrl_r;
	logic [3:0]  loop2_reference_source_r;
	logic [3:0]  loop2_loop_gain_r;
	logic        loop2_secondary_path_enable_r;
	logic [9:0]  loop2_secondary_integer_mult_r;
	logic [15:0] loop2_secondary_numerator_r;
	logic [15:0] loop2_secondary_denominator_r;
	logic [2:0]  loop2_secondary_vco_ratio_r;
	logic [1:0]  loop2_secondary_ref_divider_r;
	logic [3:0]  loop2_secondary_ref_source_r;
	logic [3:0]  loop2_secondary_gain_r;
	logic        loop2_secondary_bandwidth_r;

	// Software writes at printed offsets
	always_ff @(posedge clk) begin
		if (!nrst) begin
			loop1_ctrl_r                   <= {RST_L1_HOLD, RST_ENA};
			loop2_ctrl_r                   <= {RST_L2_HOLD, RST_ENA};
			loop2_reference_source_r       <= RST_SRC;
			loop2_loop_gain_r              <= RST_GAIN;
			loop2_secondary_path_enable_r  <= RST_ENA;
			loop2_secondary_integer_mult_r <= RST_WORD[INT_W-1:0];
			loop2_secondary_numerator_r    <= RST_WORD;
			loop2_secondary_denominator_r  <= RST_WORD;
			loop2_secondary_vco_ratio_r    <= RST_RATIO;
			loop2_secondary_ref_divider_r  <= RST_DIV;
			loop2_secondary_ref_source_r   <= RST_SRC;
			loop2_secondary_gain_r         <= RST_GAIN;
			loop2_secondary_bandwidth_r    <= RST_BW;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_L1_CTRL1:    loop1_ctrl_r <= reg_wdata[HOLD_BIT:ENA_BIT];
				OFS_L2_CTRL1:    loop2_ctrl_r <= reg_wdata[HOLD_BIT:ENA_BIT];
				OFS_L2_REFSEL:   loop2_reference_source_r <= reg_wdata[SRC_LSB+:4];
				OFS_L2_GAIN:     loop2_loop_gain_r <= reg_wdata[GAIN_LSB+:4];
				OFS_SYNC_ENA:    loop2_secondary_path_enable_r <= reg_wdata[ENA_BIT];
				OFS_SYNC_INT:    loop2_secondary_integer_mult_r <= reg_wdata[INT_W-1:0];
				OFS_SYNC_NUM:    loop2_secondary_numerator_r <= reg_wdata;
				OFS_SYNC_DEN:    loop2_secondary_denominator_r <= reg_wdata;
				OFS_SYNC_RATIO:  loop2_secondary_vco_ratio_r <= reg_wdata[RATIO_LSB+:3];
				OFS_SYNC_REFSEL: begin
					loop2_secondary_ref_divider_r <= reg_wdata[DIV_LSB+:2];
					loop2_secondary_ref_source_r  <= reg_wdata[SRC_LSB+:4];
				end
				OFS_SYNC_GAINBW: begin
					loop2_secondary_gain_r      <= reg_wdata[GAIN_LSB+:4];
					loop2_secondary_bandwidth_r <= reg_wdata[BW_BIT];
				end
				default: ;
			endcase
		end
	end

	// Registered read data; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				unique case (reg_addr)
					OFS_L1_CTRL1:    reg_rdata <= {14'h0000, loop1_ctrl_r};
					OFS_L2_CTRL1:    reg_rdata <= {14'h0000, loop2_ctrl_r};
					OFS_L2_REFSEL:   reg_rdata <= {12'h000, loop2_reference_source_r};
					OFS_L2_GAIN:     reg_rdata <= {10'h000, loop2_loop_gain_r, 2'h0};
					OFS_SYNC_ENA:    reg_rdata <= {15'h0000, loop2_secondary_path_enable_r};
					OFS_SYNC_INT:    reg_rdata <= {6'h00, loop2_secondary_integer_mult_r};
					OFS_SYNC_NUM:    reg_rdata <= loop2_secondary_numerator_r;
					OFS_SYNC_DEN:    reg_rdata <= loop2_secondary_denominator_r;
					OFS_SYNC_RATIO:  reg_rdata <= {5'h00, loop2_secondary_vco_ratio_r, 8'h00};
					OFS_SYNC_REFSEL: reg_rdata <= {8'h00, loop2_secondary_ref_divider_r,
						2'h0, loop2_secondary_ref_source_r};
					OFS_SYNC_GAINBW: reg_rdata <= {10'h000, loop2_secondary_gain_r,
						1'b0, loop2_secondary_bandwidth_r};
					default:         reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Reference and tracking decisions
	// ---------------------------------------------------------------
	logic l2_main_alive;
	logic l2_sync_alive;
	logic l1_track;
	logic l2_track;
	logic l2_sync_track;

	// Reserved codes select nothing; on the main select the loop holds, on the secondary its term drops
	assign l2_main_alive = pick_ref(ref_alive, loop2_reference_source_r, 1'b0);
	assign l2_sync_alive = pick_ref(ref_alive, loop2_secondary_ref_source_r, 1'b1);

	// Tracking only when enabled, hold clear and reference present
	assign l1_track = loop1_ctrl_r[ENA_BIT] && !loop1_ctrl_r[HOLD_BIT]
		&& loop1_ref_alive;
	assign l2_track = loop2_ctrl_r[ENA_BIT] && !loop2_ctrl_r[HOLD_BIT]
		&& l2_main_alive;
	assign l2_sync_track = l2_track && loop2_secondary_path_enable_r && l2_sync_alive;
	assign loop_tracking = {l2_track, l1_track};

	// ---------------------------------------------------------------
	// Integrators
	// ---------------------------------------------------------------
	logic [INTEG_W-1:0] integ1_r;
	logic [INTEG_W-1:0] integ2_r;
	logic [1:0]         ena_d_r;
	logic [1:0]         locked_once_r;
	logic [3:0]         sync_shift;

	// Narrow bandwidth takes one less bit of secondary gain, except at gain code 0
	assign sync_shift = (loop2_secondary_bandwidth_r && gain_shift(loop2_secondary_gain_r) != 4'h0)
		? gain_shift(loop2_secondary_gain_r) - 4'h1 : gain_shift(loop2_secondary_gain_r);

	// Enable history and whether each loop ever tracked
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ena_d_r       <= 2'b00;
			locked_once_r <= 2'b00;
		end else begin
			ena_d_r <= {loop2_ctrl_r[ENA_BIT], loop1_ctrl_r[ENA_BIT]};
			if (l1_track)
				locked_once_r[0] <= 1'b1;
			if (l2_track)
				locked_once_r[1] <= 1'b1;
		end
	end

	// Loop one integrator: cold start, track, or hold
	always_ff @(posedge clk) begin
		if (!nrst) begin
			integ1_r <= INTEG_INIT[INTEG_W-1:0];
		end else if (loop1_ctrl_r[ENA_BIT] && !ena_d_r[0] && !locked_once_r[0]) begin
			integ1_r <= INTEG_INIT[INTEG_W-1:0];
		end else if (l1_track) begin
			integ1_r <= integ1_r + scaled(loop1_error, 4'h0);
		end // Otherwise held
	end

	// Loop two integrator with main and secondary feedback terms
	always_ff @(posedge clk) begin
		if (!nrst) begin
			integ2_r <= INTEG_INIT[INTEG_W-1:0];
		end else if (loop2_ctrl_r[ENA_BIT] && !ena_d_r[1] && !locked_once_r[1]) begin
			integ2_r <= INTEG_INIT[INTEG_W-1:0];
		end else if (l2_track) begin
			integ2_r <= integ2_r + scaled(loop2_error, gain_shift(loop2_loop_gain_r))
				+ (l2_sync_track ? scaled(loop2_sync_error, sync_shift)
				: {INTEG_W{1'b0}});
		end // Otherwise held
	end

	assign loop1_osc_ctrl = integ1_r;
	assign loop2_osc_ctrl = integ2_r;

	// Either loop feeds either system clock
	assign main_system_clock_ctrl = main_system_clock_loop_sel ? integ2_r : integ1_r;
	assign asynchronous_system_clock_ctrl = asynchronous_system_clock_loop_sel ? integ2_r : integ1_r;

	// ---------------------------------------------------------------
	// Secondary path configuration outputs
	// ---------------------------------------------------------------
	always_comb begin
		sync_cfg              = '0;
		sync_cfg.path_enable  = loop2_secondary_path_enable_r;
		sync_cfg.integer_mult = loop2_secondary_integer_mult_r;
		sync_cfg.numerator    = loop2_secondary_numerator_r;
		sync_cfg.denominator  = loop2_secondary_denominator_r;
		sync_cfg.vco_ratio    = loop2_secondary_vco_ratio_r[2] ? 5'h10
			: 5'(5'h01 << loop2_secondary_vco_ratio_r[1:0]);
		sync_cfg.ref_divider  = 4'(4'h1 << loop2_secondary_ref_divider_r);
		sync_cfg.ref_source   = loop2_secondary_ref_source_r;
		sync_cfg.gain         = 9'(9'h001 << gain_shift(loop2_secondary_gain_r));
		sync_cfg.narrow_bw    = loop2_secondary_bandwidth_r;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_hold_freezes_l2: assert property (@(posedge clk) disable iff (!nrst)
		loop2_ctrl_r[HOLD_BIT] && !reg_wr |=> $stable(integ2_r))
		else $error("loop two integrator moved while holding");

	a_noref_freezes_l1: assert property (@(posedge clk) disable iff (!nrst)
		!loop1_ref_alive && ena_d_r[0] |=> $stable(integ1_r))
		else $error("loop one integrator moved without reference");

	a_resume_track: assert property (@(posedge clk) disable iff (!nrst)
		loop2_ctrl_r[ENA_BIT] && !loop2_ctrl_r[HOLD_BIT] && l2_main_alive |-> loop_tracking[1])
		else $error("loop two not tracking with reference present");

	a_reserved_none: assert property (@(posedge clk) disable iff (!nrst)
		loop2_secondary_ref_source_r == SRC_FRM2 |-> !l2_sync_alive)
		else $error("reserved secondary code chose a reference");

	a_ratio_decode: assert property (@(posedge clk) disable iff (!nrst)
		loop2_secondary_vco_ratio_r[2] |-> sync_cfg.vco_ratio == 5'h10)
		else $error("vco ratio top code not sixteen");

	a_gain_saturate: assert property (@(posedge clk) disable iff (!nrst)
		loop2_secondary_gain_r[3] |-> sync_cfg.gain == 9'h100)
		else $error("gain above seven not 256");

	a_cold_start: assert property (@(posedge clk) disable iff (!nrst)
		$rose(loop2_ctrl_r[ENA_BIT]) && !locked_once_r[1] |=> integ2_r == INTEG_INIT[INTEG_W-1:0])
		else $error("cold start did not load start value");

	a_ctrl_readback: assert property (@(posedge clk) disable iff (!nrst)
		reg_rd && reg_addr == OFS_L1_CTRL1 && !reg_wr
		|=> reg_rvalid && reg_rdata[HOLD_BIT:ENA_BIT] == $past(loop1_ctrl_r))
		else $error("loop one control read back wrong");

	a_div_decode: assert property (@(posedge clk) disable iff (!nrst)
		loop2_secondary_ref_divider_r == 2'h3 |-> sync_cfg.ref_divider == 4'h8)
		else $error("reference divider code three not eight");

	a_ratio_eight: assert property (@(posedge clk) disable iff (!nrst)
		loop2_secondary_vco_ratio_r == 3'h3 |-> sync_cfg.vco_ratio == 5'h08)
		else $error("vco ratio code three not eight");

	a_main_frame2: assert property (@(posedge clk) disable iff (!nrst)
		loop2_reference_source_r == SRC_FRM2
		|-> l2_main_alive == ref_alive.audio_port2_rx_frame_clock)
		else $error("main select did not take frame clock two");

	a_sync_master_clock_in_two: assert property (@(posedge clk) disable iff (!nrst)
		loop2_secondary_ref_source_r == SRC_MCLK_TWO
		|-> l2_sync_alive == ref_alive.master_clock_in_two)
		else $error("secondary select did not take master clock two");

	a_noref_freezes_l2: assert property (@(posedge clk) disable iff (!nrst)
		!l2_main_alive && ena_d_r[1] |=> $stable(integ2_r))
		else $error("loop two integrator moved without reference");

	a_hold_keeps_l1: assert property (@(posedge clk) disable iff (!nrst)
		loop1_ctrl_r[HOLD_BIT] && ena_d_r[0] |=> $stable(integ1_r))
		else $error("loop one integrator moved while holding");

	a_cold_start_l1: assert property (@(posedge clk) disable iff (!nrst)
		$rose(loop1_ctrl_r[ENA_BIT]) && !locked_once_r[0]
		|=> integ1_r == INTEG_INIT[INTEG_W-1:0])
		else $error("loop one cold start did not load start value");

endmodule : fsc_control

// file: bench/fsc_control_test.sv
/*
 * Self-checking bench for the loop control block: register port, field
 * decode, reference selection, tracking, hold-oscillate and clock muxing.
 * Assumes rtl/fsc_pkg.sv and rtl/fsc_control.sv are compiled first.
 */
`timescale 1ns/1ps
module fsc_control_test;
	import fsc_pkg::*;

	// ---------------------------------------------------------------
	// Signals and instance
	// ---------------------------------------------------------------
	logic               clk;
	logic               nrst;
	logic               reg_wr;
	logic               reg_rd;
	logic [15:0]        reg_addr;
	logic [15:0]        reg_wdata;
	logic [15:0]        reg_rdata;
	logic               reg_rvalid;
	fsc_ref_alive_t     ref_alive;
	logic               loop1_ref_alive;
	logic signed [15:0] loop1_error;
	logic signed [15:0] loop2_error;
	logic signed [15:0] loop2_sync_error;
	logic               main_system_clock_loop_sel;
	logic               asynchronous_system_clock_loop_sel;
	logic [15:0]        loop1_osc_ctrl;
	logic [15:0]        loop2_osc_ctrl;
	logic [1:0]         loop_tracking;
	logic [15:0]        main_system_clock_ctrl;
	logic [15:0]        asynchronous_system_clock_ctrl;
	fsc_sync_cfg_t      sync_cfg;
	logic [15:0]        e1;
	logic [15:0]        e2;
	logic [15:0]        rv;
	int                 mismatches;
	int                 tests_run;
	// Map: offsets, reset values, readable bits; last entry is unmapped
	logic [15:0] m_a [12] = '{16'h0171, 16'h0191, 16'h0196, 16'h0199, 16'h01A1, 16'h01A2,
		16'h01A3, 16'h01A4, 16'h01A5, 16'h01A6, 16'h01A7, 16'h01A8};
	logic [15:0] m_r [12] = '{16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000};
	logic [15:0] m_m [12] = '{16'h0003, 16'h0003, 16'h000F, 16'h003C, 16'h0001, 16'h03FF,
		16'hFFFF, 16'hFFFF, 16'h0700, 16'h00CF, 16'h003D, 16'h0000};
	// Presence bit of each source code, -1 where the code is reserved
	int src_bit [16] = '{10, 9, -1, 8, 7, 6, -1, -1, 5, 4, 3, -1, 2, 1, 0, -1};

	fsc_control #(.INTEG_W(16), .INTEG_INIT(16'h8000)) uut (
		.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.ref_alive(ref_alive), .loop1_ref_alive(loop1_ref_alive),
		.loop1_error(loop1_error), .loop2_error(loop2_error),
		.loop2_sync_error(loop2_sync_error), .main_system_clock_loop_sel(main_system_clock_loop_sel),
		.asynchronous_system_clock_loop_sel(asynchronous_system_clock_loop_sel), .loop1_osc_ctrl(loop1_osc_ctrl),
		.loop2_osc_ctrl(loop2_osc_ctrl), .loop_tracking(loop_tracking),
		.main_system_clock_ctrl(main_system_clock_ctrl),
		.asynchronous_system_clock_ctrl(asynchronous_system_clock_ctrl),
		.sync_cfg(sync_cfg));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out;
		if (mismatches == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read answer comes with the one-cycle valid pulse; the wait is bounded
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		int n;
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (reg_rvalid !== 1'b1) begin
			mismatches++;
			close_out();
		end
		d = reg_rdata;
	endtask : rd

	// One cycle of error on one loop, then the integrator is compared
	task automatic pulse(input logic two, input logic signed [15:0] e, input logic [15:0] exp);
		@(posedge clk);
		if (two) loop2_error <= e;
		else loop1_error <= e;
		@(posedge clk);
		loop1_error <= 16'sd0;
		loop2_error <= 16'sd0;
		#1;
		check(two ? loop2_osc_ctrl : loop1_osc_ctrl, exp);
	endtask : pulse

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 12; i++) begin
			rd(m_a[i], rv);
			check(rv, m_r[i]);
		end
		check(loop1_osc_ctrl, 16'h8000);
		check(loop2_osc_ctrl, 16'h8000);
		check({14'h0, loop_tracking}, 16'h0000);
	endtask : t_reset

	// Secondary path field decode for every code
	task automatic t_decode;
		for (int c = 0; c < 16; c++) begin
			wr(OFS_SYNC_GAINBW, 16'((c << 2) | (c & 1)));
			check(16'(sync_cfg.gain), (c > 7) ? 16'h0100 : 16'(1 << c));
			check({15'h0, sync_cfg.narrow_bw}, 16'(c & 1));
		end
		for (int c = 0; c < 8; c++) begin
			wr(OFS_SYNC_RATIO, 16'(c << 8));
			check(16'(sync_cfg.vco_ratio), (c > 3) ? 16'h0010 : 16'(1 << c));
		end
		for (int c = 0; c < 4; c++) begin
			wr(OFS_SYNC_REFSEL, 16'(c << 6));
			check(16'(sync_cfg.ref_divider), 16'(1 << c));
		end
		wr(OFS_SYNC_INT, 16'hFFFF);
		check(16'(sync_cfg.integer_mult), 16'h03FF);
		wr(OFS_SYNC_NUM, 16'h1234);
		check(sync_cfg.numerator, 16'h1234);
		wr(OFS_SYNC_DEN, 16'hABCD);
		check(sync_cfg.denominator, 16'hABCD);
		wr(OFS_SYNC_ENA, 16'h0001);
		check({15'h0, sync_cfg.path_enable}, 16'h0001);
		wr(OFS_SYNC_ENA, 16'h0000);
	endtask : t_decode

	// Every main source code, with its own reference present and then absent
	task automatic t_main_source;
		int b;
		wr(OFS_L2_REFSEL, 16'h0000);
		wr(OFS_L2_CTRL1, 16'h0001);
		for (int c = 0; c < 16; c++) begin
			b = src_bit[c];
			wr(OFS_L2_REFSEL, 16'(c));
			check({15'h0, loop_tracking[1]}, {15'h0, b >= 0});
			if (b >= 0) begin
				@(posedge clk);
				ref_alive <= fsc_ref_alive_t'(11'h7FF & ~(11'h001 << b));
				@(posedge clk);
				#1;
				check({15'h0, loop_tracking[1]}, 16'h0000);
				@(posedge clk);
				ref_alive <= fsc_ref_alive_t'(11'h7FF);
				@(posedge clk);
				#1;
			end
		end
		wr(OFS_L2_REFSEL, 16'h0000);
	endtask : t_main_source

	// Loop two: gain scaling, hold freezes the integrator, clearing resumes
	task automatic t_track2;
		wr(OFS_L2_GAIN, 16'h000C);
		e2 = e2 + 16'h0010;
		pulse(1'b1, 16'sd2, e2);
		wr(OFS_L2_GAIN, 16'h0024);
		e2 = e2 + 16'h0100;
		pulse(1'b1, 16'sd1, e2);
		wr(OFS_L2_CTRL1, 16'h0003);
		check({15'h0, loop_tracking[1]}, 16'h0000);
		@(posedge clk);
		loop2_error <= 16'sd5;
		repeat (4) @(posedge clk);
		loop2_error <= 16'sd0;
		#1;
		check(loop2_osc_ctrl, e2);
		wr(OFS_L2_CTRL1, 16'h0001);
		wr(OFS_L2_GAIN, 16'h0000);
		e2 = e2 + 16'h0001;
		pulse(1'b1, 16'sd1, e2);
	endtask : t_track2

	// Loop one: tracks at fixed gain, holds while its reference is gone
	task automatic t_track1;
		wr(OFS_L1_CTRL1, 16'h0001);
		e1 = e1 + 16'h0003;
		pulse(1'b0, 16'sd3, e1);
		@(posedge clk);
		loop1_ref_alive <= 1'b0;
		loop1_error     <= 16'sd7;
		repeat (4) @(posedge clk);
		loop1_error <= 16'sd0;
		#1;
		check(loop1_osc_ctrl, e1);
		check({15'h0, loop_tracking[0]}, 16'h0000);
		@(posedge clk);
		loop1_ref_alive <= 1'b1;
		e1 = e1 + 16'h0002;
		pulse(1'b0, 16'sd2, e1);
	endtask : t_track1

	// Both system clock selections, every combination
	task automatic t_clock_sel;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			main_system_clock_loop_sel   <= s[0];
			asynchronous_system_clock_loop_sel <= s[1];
			@(posedge clk);
			#1;
			check(main_system_clock_ctrl, s[0] ? e2 : e1);
			check(asynchronous_system_clock_ctrl, s[1] ? e2 : e1);
		end
	endtask : t_clock_sel

	// Secondary term for one setting; fields first, path enable last.
	// Divide by one: presence flags stand for a reference already in range
	task automatic sync_step(input logic [15:0] gbw, input logic [15:0] sel,
		input logic [15:0] inc);
		wr(OFS_SYNC_GAINBW, gbw);
		wr(OFS_SYNC_REFSEL, sel);
		wr(OFS_SYNC_ENA, 16'h0001);
		@(posedge clk);
		loop2_sync_error <= 16'sd1;
		@(posedge clk);
		loop2_sync_error <= 16'sd0;
		#1;
		e2 = e2 + inc;
		check(loop2_osc_ctrl, e2);
		wr(OFS_SYNC_ENA, 16'h0000);
	endtask : sync_step

	// Every secondary source code at gain 4, then narrow, saturated, disabled
	task automatic t_sync;
		for (int c = 0; c < 16; c++) begin
			sync_step(16'h0008, 16'(c),
				(c == 13 || src_bit[c] < 0) ? 16'h0000 : 16'h0004);
		end
		sync_step(16'h0009, 16'h0000, 16'h0002);
		sync_step(16'h0001, 16'h0000, 16'h0001);
		sync_step(16'h0024, 16'h0000, 16'h0100);
		@(posedge clk);
		loop2_sync_error <= 16'sd1;
		@(posedge clk);
		loop2_sync_error <= 16'sd0;
		#1;
		check(loop2_osc_ctrl, e2);
	endtask : t_sync

	// All ones written everywhere; reserved bits and the unmapped place read 0
	task automatic t_masks;
		for (int i = 0; i < 12; i++) begin
			wr(m_a[i], 16'hFFFF);
			rd(m_a[i], rv);
			check(rv, m_m[i]);
		end
	endtask : t_masks

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		nrst              = 1'b0;
		reg_wr            = 1'b0;
		reg_rd            = 1'b0;
		reg_addr          = 16'h0000;
		reg_wdata         = 16'h0000;
		ref_alive         = fsc_ref_alive_t'(11'h7FF);
		loop1_ref_alive   = 1'b1;
		loop1_error       = 16'sd0;
		loop2_error       = 16'sd0;
		loop2_sync_error  = 16'sd0;
		main_system_clock_loop_sel   = 1'b0;
		asynchronous_system_clock_loop_sel = 1'b0;
		e1                = 16'h8000;
		e2                = 16'h8000;
		mismatches        = 0;
		tests_run         = 0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_decode();
		t_main_source();
		t_track2();
		t_track1();
		t_clock_sel();
		t_sync();
		t_masks();
		// Reset in mid-run brings every field back to its default
		@(posedge clk);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		close_out();
	end
endmodule : fsc_control_test
